// ==== rtl/exposure_hdr_sequencer.v ====
// Function
// - mode bit picks programmed length or external pin interval; resets clear
// - external: exposure runs from pin a rise to frame request rise
// - internal: exposure is 129 periods times (0.43 overhead plus length)
// - overhead length comes from the register at index 73
// - external: 129 times 0.43 overhead periods added to measured interval
// - a one cycle gap between pin a and frame request is accepted
// - internal: programmed length of 0 gives the shortest exposure, the overhead alone
// - dual exposure works in both exposure modes; piecewise knee durations apply only in internal mode
// - dual bit, reset clear, gives odd and even rows separate exposures
// - internal dual: even rows use primary, odd rows second length
// - external dual: pin a times even lines, pin b odd lines
// - colour type bit cleared makes interleave follow colour filter pairs
// - piecewise mode changes clip level up to twice, three slopes
// - bright pixels held at programmed clip voltage for programmed time
// - knees follow clip voltages, slopes follow knee durations
// - clip fields are 7 bits: enable on top, six bit value, default 96
//
// The AXI4-Lite slave port was decided locally.
`include "exposure_hdr_sequencer_defines.vh"

module exposure_hdr_sequencer #(
	parameter ROW_WIDTH = 11
) (
	input  wire                 i_mclk,
	input  wire                 i_rst_n,
	input  wire [11:0]          i_axi_awaddr,
	input  wire                 i_axi_awvalid,
	output wire                 o_axi_awready,
	input  wire [31:0]          i_axi_wdata,
	input  wire [3:0]           i_axi_wstrb,
	input  wire                 i_axi_wvalid,
	output wire                 o_axi_wready,
	output reg  [1:0]           o_axi_bresp,
	output reg                  o_axi_bvalid,
	input  wire                 i_axi_bready,
	input  wire [11:0]          i_axi_araddr,
	input  wire                 i_axi_arvalid,
	output wire                 o_axi_arready,
	output reg  [31:0]          o_axi_rdata,
	output reg  [1:0]           o_axi_rresp,
	output reg                  o_axi_rvalid,
	input  wire                 i_axi_rready,
	input  wire                 i_exposure_start_pin_a,
	input  wire                 i_exposure_start_pin_b,
	input  wire                 i_frame_req,
	input  wire [ROW_WIDTH-1:0] i_row_index,
	output reg                  o_integrate_even,
	output reg                  o_integrate_odd,
	output reg                  o_overhead,
	output reg                  o_clip_enable,
	output reg  [5:0]           o_clip_value,
	output reg                  o_row_second_exposure
);

	localparam ST_IDLE    = 2'd0;
	localparam ST_MEASURE = 2'd1;
	localparam ST_RUN     = 2'd2;

	// length in hundredths of a clock period
	function [39:0] scaled_len;
		input [7:0]  fot;
		input [23:0] len;
		begin
			scaled_len = `ROW_CLOCKS * (`FOT_PCT * {32'h0, fot}
				+ `PCT_SCALE * {16'h0, len});
		end
	endfunction

	// mono sensors alternate each row, colour sensors each pair of rows
	function second_row;
		input                 mono;
		input [ROW_WIDTH-1:0] row;
		begin
			second_row = mono ? row[0] : row[1];
		end
	endfunction

	// registers
	reg        colour_type;
	reg [1:0]  mode_ctrl;
	reg [23:0] primary_exposure_length;
	reg [23:0] odd_row_exposure_length;
	reg [23:0] knee_one_length;
	reg [23:0] knee_two_length;
	reg [1:0]  slope_count;
	reg [7:0]  fot_length;
	reg [6:0]  clip_voltage_two;
	reg [6:0]  clip_voltage_three;
	reg [23:0] measured_interval;

	// sequencer state
	reg [1:0]  state;
	reg        run_external;
	reg        run_dual;
	reg        just_started;
	reg        measure_even;
	reg        measure_odd;
	reg [23:0] interval_count;
	reg [39:0] target_even;
	reg [39:0] target_odd;
	reg        start_timers;

	reg        pin_a_meta, pin_a_sync, pin_a_prev;
	reg        pin_b_meta, pin_b_sync, pin_b_prev;
	reg        frame_meta, frame_sync, frame_prev;

	wire        pin_a_rise;
	wire        pin_b_rise;
	wire        frame_rise;
	wire        busy_even;
	wire        busy_odd;
	wire [39:0] elapsed_even;
	wire [39:0] fot_scaled;
	wire [39:0] remaining_even;
	wire [39:0] knee_one_scaled;
	wire [39:0] knee_two_scaled;

	// all three pins get the same two-stage delay, so a one cycle gap
	// between edges survives the crossing
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pin_a_meta <= 1'b0;
			pin_a_sync <= 1'b0;
			pin_a_prev <= 1'b0;
			pin_b_meta <= 1'b0;
			pin_b_sync <= 1'b0;
			pin_b_prev <= 1'b0;
			frame_meta <= 1'b0;
			frame_sync <= 1'b0;
			frame_prev <= 1'b0;
		end else begin
			pin_a_meta <= i_exposure_start_pin_a;
			pin_a_sync <= pin_a_meta;
			pin_a_prev <= pin_a_sync;
			pin_b_meta <= i_exposure_start_pin_b;
			pin_b_sync <= pin_b_meta;
			pin_b_prev <= pin_b_sync;
			frame_meta <= i_frame_req;
			frame_sync <= frame_meta;
			frame_prev <= frame_sync;
		end
	end

	assign pin_a_rise = pin_a_sync & ~pin_a_prev;
	assign pin_b_rise = pin_b_sync & ~pin_b_prev;
	assign frame_rise = frame_sync & ~frame_prev;

	assign fot_scaled = scaled_len(fot_length, 24'h0);
	assign knee_one_scaled = scaled_len(fot_length, knee_one_length);
	assign knee_two_scaled = scaled_len(fot_length, knee_two_length);
	assign remaining_even = target_even - elapsed_even;

	exposure_timer #(
		.WIDTH (40)
	) u_timer_even (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_start   (start_timers),
		.i_target  (target_even),
		.o_busy    (busy_even),
		.o_elapsed (elapsed_even)
	);

	exposure_timer #(
		.WIDTH (40)
	) u_timer_odd (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_start   (start_timers),
		.i_target  (target_odd),
		.o_busy    (busy_odd),
		.o_elapsed ()
	);

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			run_external <= 1'b0;
			run_dual <= 1'b0;
			just_started <= 1'b0;
			measure_even <= 1'b0;
			measure_odd <= 1'b0;
			interval_count <= 24'h0;
			measured_interval <= 24'h0;
			target_even <= 40'h0;
			target_odd <= 40'h0;
			start_timers <= 1'b0;
		end else begin
			start_timers <= 1'b0;
			just_started <= start_timers;
			case (state)
			ST_IDLE: begin
				run_external <= mode_ctrl[`MODE_EXTERNAL_BIT];
				run_dual <= mode_ctrl[`MODE_DUAL_BIT];
				if (mode_ctrl[`MODE_EXTERNAL_BIT] && pin_a_rise) begin
					measure_even <= 1'b1;
					measure_odd <= ~mode_ctrl[`MODE_DUAL_BIT];
					interval_count <= 24'h1;
					state <= ST_MEASURE;
				end else if (!mode_ctrl[`MODE_EXTERNAL_BIT] && frame_rise) begin
					target_even <= scaled_len(fot_length,
						primary_exposure_length);
					target_odd <= scaled_len(fot_length,
						mode_ctrl[`MODE_DUAL_BIT] ?
						odd_row_exposure_length : primary_exposure_length);
					start_timers <= 1'b1;
					state <= ST_RUN;
				end
			end
			ST_MEASURE: begin
				if (run_dual && pin_b_rise)
					measure_odd <= 1'b1;
				if (frame_rise) begin
					measured_interval <= interval_count;
					target_even <= fot_scaled;
					target_odd <= fot_scaled;
					start_timers <= 1'b1;
					state <= ST_RUN;
				end else if (interval_count != 24'hffffff) begin
					interval_count <= interval_count + 24'h1;
				end
			end
			ST_RUN: begin
				// flags drop as the timers rise, so integration has no gap
				measure_even <= 1'b0;
				measure_odd <= 1'b0;
				if (!start_timers && !just_started && !busy_even && !busy_odd)
					state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// clip schedule: first clip until the first knee duration remains,
	// second until the second knee remains; external mode has no end
	// time in advance, so it clips during the interval and the overhead
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_integrate_even <= 1'b0;
			o_integrate_odd <= 1'b0;
			o_overhead <= 1'b0;
			o_clip_enable <= 1'b0;
			o_clip_value <= 6'h0;
			o_row_second_exposure <= 1'b0;
		end else begin
			o_integrate_even <= measure_even | busy_even;
			o_integrate_odd <= measure_odd | busy_odd;
			o_overhead <= busy_even & (run_external |
				(remaining_even <= fot_scaled));
			o_row_second_exposure <= run_dual &
				second_row(colour_type, i_row_index);
			o_clip_enable <= 1'b0;
			o_clip_value <= 6'h0;
			if (run_external) begin
				if (measure_even && slope_count >= 2'd2 &&
						clip_voltage_two[`CLIP_ENABLE_BIT]) begin
					o_clip_enable <= 1'b1;
					o_clip_value <= clip_voltage_two[5:0];
				end else if (busy_even && slope_count == 2'd3 &&
						clip_voltage_three[`CLIP_ENABLE_BIT]) begin
					o_clip_enable <= 1'b1;
					o_clip_value <= clip_voltage_three[5:0];
				end
			end else if (busy_even) begin
				if (slope_count >= 2'd2 && remaining_even > knee_one_scaled &&
						clip_voltage_two[`CLIP_ENABLE_BIT]) begin
					o_clip_enable <= 1'b1;
					o_clip_value <= clip_voltage_two[5:0];
				end else if (slope_count == 2'd3 &&
						remaining_even > knee_two_scaled &&
						clip_voltage_three[`CLIP_ENABLE_BIT]) begin
					o_clip_enable <= 1'b1;
					o_clip_value <= clip_voltage_three[5:0];
				end
			end
		end
	end

	// axi4-lite write path: address and data held until both are here
	reg        aw_held;
	reg [7:0]  aw_index;
	reg        w_held;
	reg [31:0] w_data;
	reg        w_strb0;
	wire       write_go;
	wire [7:0] wi;
	wire [7:0] wb;
	reg        write_hit;

	assign o_axi_awready = ~aw_held & ~o_axi_bvalid;
	assign o_axi_wready = ~w_held & ~o_axi_bvalid;
	assign write_go = aw_held & w_held & ~o_axi_bvalid;
	assign wi = aw_index;
	assign wb = w_data[7:0];

	always @* begin
		write_hit = 1'b1;
		case (wi)
		`IDX_SENSOR_COLOUR_TYPE, `IDX_EXPOSURE_MODE,
		`IDX_PRIMARY_EXP, `IDX_PRIMARY_EXP + 8'h1, `IDX_PRIMARY_EXP + 8'h2,
		`IDX_KNEE_ONE, `IDX_KNEE_ONE + 8'h1, `IDX_KNEE_ONE + 8'h2,
		`IDX_KNEE_TWO, `IDX_KNEE_TWO + 8'h1, `IDX_KNEE_TWO + 8'h2,
		`IDX_SLOPE_COUNT, `IDX_ODD_EXP, `IDX_ODD_EXP + 8'h1,
		`IDX_ODD_EXP + 8'h2, `IDX_FOT_LENGTH, `IDX_CLIP_TWO,
		`IDX_CLIP_THREE: write_hit = 1'b1;
		default: write_hit = 1'b0;
		endcase
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			aw_held <= 1'b0;
			aw_index <= 8'h0;
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb0 <= 1'b0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= `RESP_OKAY;
			colour_type <= `RST_COLOUR_TYPE;
			mode_ctrl <= `RST_EXPOSURE_MODE;
			primary_exposure_length <= `RST_PRIMARY_EXP;
			odd_row_exposure_length <= `RST_ODD_EXP;
			knee_one_length <= `RST_KNEE;
			knee_two_length <= `RST_KNEE;
			slope_count <= `RST_SLOPE_COUNT;
			fot_length <= `RST_FOT_LENGTH;
			clip_voltage_two <= `RST_CLIP;
			clip_voltage_three <= `RST_CLIP;
		end else begin
			if (i_axi_awvalid && o_axi_awready) begin
				aw_held <= 1'b1;
				aw_index <= i_axi_awaddr[9:2];
			end
			if (i_axi_wvalid && o_axi_wready) begin
				w_held <= 1'b1;
				w_data <= i_axi_wdata;
				w_strb0 <= i_axi_wstrb[0];
			end
			if (o_axi_bvalid && i_axi_bready)
				o_axi_bvalid <= 1'b0;
			if (write_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_axi_bvalid <= 1'b1;
				o_axi_bresp <= (write_hit && aw_held) ?
					`RESP_OKAY : `RESP_SLVERR;
				if (w_strb0) begin
					case (wi)
					`IDX_SENSOR_COLOUR_TYPE: colour_type <= wb[0];
					`IDX_EXPOSURE_MODE: mode_ctrl <= wb[1:0];
					`IDX_PRIMARY_EXP: primary_exposure_length[7:0] <= wb;
					`IDX_PRIMARY_EXP + 8'h1:
						primary_exposure_length[15:8] <= wb;
					`IDX_PRIMARY_EXP + 8'h2:
						primary_exposure_length[23:16] <= wb;
					`IDX_KNEE_ONE: knee_one_length[7:0] <= wb;
					`IDX_KNEE_ONE + 8'h1: knee_one_length[15:8] <= wb;
					`IDX_KNEE_ONE + 8'h2: knee_one_length[23:16] <= wb;
					`IDX_KNEE_TWO: knee_two_length[7:0] <= wb;
					`IDX_KNEE_TWO + 8'h1: knee_two_length[15:8] <= wb;
					`IDX_KNEE_TWO + 8'h2: knee_two_length[23:16] <= wb;
					`IDX_SLOPE_COUNT: slope_count <= wb[1:0];
					`IDX_ODD_EXP: odd_row_exposure_length[7:0] <= wb;
					`IDX_ODD_EXP + 8'h1:
						odd_row_exposure_length[15:8] <= wb;
					`IDX_ODD_EXP + 8'h2:
						odd_row_exposure_length[23:16] <= wb;
					`IDX_FOT_LENGTH: fot_length <= wb;
					`IDX_CLIP_TWO: clip_voltage_two <= wb[6:0];
					`IDX_CLIP_THREE: clip_voltage_three <= wb[6:0];
					default: fot_length <= fot_length;
					endcase
				end
			end
		end
	end

	// axi4-lite read path: one read at a time, data one cycle after address
	reg [7:0] next_rdata;
	reg       read_hit;

	assign o_axi_arready = ~o_axi_rvalid;

	always @* begin
		next_rdata = 8'h0;
		read_hit = 1'b1;
		case (i_axi_araddr[9:2])
		`IDX_SENSOR_COLOUR_TYPE: next_rdata = {7'h0, colour_type};
		`IDX_EXPOSURE_MODE: next_rdata = {6'h0, mode_ctrl};
		`IDX_PRIMARY_EXP: next_rdata = primary_exposure_length[7:0];
		`IDX_PRIMARY_EXP + 8'h1: next_rdata = primary_exposure_length[15:8];
		`IDX_PRIMARY_EXP + 8'h2: next_rdata = primary_exposure_length[23:16];
		`IDX_KNEE_ONE: next_rdata = knee_one_length[7:0];
		`IDX_KNEE_ONE + 8'h1: next_rdata = knee_one_length[15:8];
		`IDX_KNEE_ONE + 8'h2: next_rdata = knee_one_length[23:16];
		`IDX_KNEE_TWO: next_rdata = knee_two_length[7:0];
		`IDX_KNEE_TWO + 8'h1: next_rdata = knee_two_length[15:8];
		`IDX_KNEE_TWO + 8'h2: next_rdata = knee_two_length[23:16];
		`IDX_SLOPE_COUNT: next_rdata = {6'h0, slope_count};
		`IDX_ODD_EXP: next_rdata = odd_row_exposure_length[7:0];
		`IDX_ODD_EXP + 8'h1: next_rdata = odd_row_exposure_length[15:8];
		`IDX_ODD_EXP + 8'h2: next_rdata = odd_row_exposure_length[23:16];
		`IDX_FOT_LENGTH: next_rdata = fot_length;
		`IDX_CLIP_TWO: next_rdata = {1'b0, clip_voltage_two};
		`IDX_CLIP_THREE: next_rdata = {1'b0, clip_voltage_three};
		`IDX_STATUS: next_rdata = {4'h0, o_overhead, o_integrate_odd,
			o_integrate_even, (state != ST_IDLE)};
		`IDX_MEASURED: next_rdata = measured_interval[7:0];
		`IDX_MEASURED + 8'h1: next_rdata = measured_interval[15:8];
		`IDX_MEASURED + 8'h2: next_rdata = measured_interval[23:16];
		default: read_hit = 1'b0;
		endcase
	end

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= 32'h0;
			o_axi_rresp <= `RESP_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			o_axi_rvalid <= 1'b1;
			o_axi_rdata <= {24'h0, next_rdata};
			o_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (o_axi_rvalid && i_axi_rready) begin
			o_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ==== inc/exposure_hdr_sequencer_defines.vh ====
`ifndef EXPOSURE_HDR_SEQUENCER_DEFINES_VH
`define EXPOSURE_HDR_SEQUENCER_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_SENSOR_COLOUR_TYPE 8'h27
`define IDX_EXPOSURE_MODE      8'h29
`define IDX_PRIMARY_EXP        8'h2a
`define IDX_KNEE_ONE           8'h30
`define IDX_KNEE_TWO           8'h33
`define IDX_SLOPE_COUNT        8'h36
`define IDX_ODD_EXP            8'h38
`define IDX_FOT_LENGTH         8'h49
`define IDX_CLIP_TWO           8'h59
`define IDX_CLIP_THREE         8'h5a
`define IDX_STATUS             8'h80
`define IDX_MEASURED           8'h81

// field positions
`define MODE_EXTERNAL_BIT 0
`define MODE_DUAL_BIT     1
`define CLIP_ENABLE_BIT   6

// reset values
`define RST_COLOUR_TYPE   1'b1
`define RST_EXPOSURE_MODE 2'h0
`define RST_PRIMARY_EXP   24'h000800
`define RST_ODD_EXP       24'h000440
`define RST_KNEE          24'h000001
`define RST_SLOPE_COUNT   2'h1
`define RST_CLIP          7'h60
`define RST_FOT_LENGTH    8'h0a

// timing: lengths are kept in hundredths of a clock period
`define ROW_CLOCKS 40'd129
`define FOT_PCT    40'd43
`define PCT_SCALE  40'd100

// axi responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== rtl/exposure_timer.v ====
`include "exposure_hdr_sequencer_defines.vh"

module exposure_timer #(
	parameter WIDTH = 40
) (
	input  wire             i_mclk,
	input  wire             i_rst_n,
	input  wire             i_start,
	input  wire [WIDTH-1:0] i_target,
	output reg              o_busy,
	output reg  [WIDTH-1:0] o_elapsed
);

	// counting up by the scale step avoids a divider; the run lasts
	// ceil(target / 100) cycles, so a fractional period rounds up
	wire [WIDTH-1:0] step;
	wire [WIDTH-1:0] next_elapsed;

	assign step = `PCT_SCALE;
	assign next_elapsed = o_elapsed + step;

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_busy <= 1'b0;
			o_elapsed <= {WIDTH{1'b0}};
		end else if (i_start) begin
			o_busy <= (i_target != {WIDTH{1'b0}});
			o_elapsed <= {WIDTH{1'b0}};
		end else if (o_busy) begin
			if (next_elapsed >= i_target)
				o_busy <= 1'b0;
			o_elapsed <= next_elapsed;
		end
	end

endmodule

// ==== testbench/exposure_hdr_sequencer_chk.sv ====
module exposure_hdr_sequencer_chk (
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic        i_axi_awvalid,
	input wire logic        o_axi_awready,
	input wire logic        i_axi_wvalid,
	input wire logic        o_axi_wready,
	input wire logic [1:0]  o_axi_bresp,
	input wire logic        o_axi_bvalid,
	input wire logic        i_axi_bready,
	input wire logic        i_axi_arvalid,
	input wire logic        o_axi_arready,
	input wire logic [31:0] o_axi_rdata,
	input wire logic [1:0]  o_axi_rresp,
	input wire logic        o_axi_rvalid,
	input wire logic        i_axi_rready,
	input wire logic        o_integrate_even,
	input wire logic        o_integrate_odd,
	input wire logic        o_overhead
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	b_hold_a: assert property (o_axi_bvalid && !i_axi_bready |=>
		o_axi_bvalid && $stable(o_axi_bresp))
		else $error("write response dropped before bready");
	r_hold_a: assert property (o_axi_rvalid && !i_axi_rready |=>
		o_axi_rvalid && $stable(o_axi_rdata) && $stable(o_axi_rresp))
		else $error("read response changed before rready");
	w_refuse_a: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
		else $error("write accepted while response pending");
	ar_refuse_a: assert property (o_axi_rvalid |-> !o_axi_arready)
		else $error("read accepted while data pending");
	r_latency_a: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
		else $error("read data not one cycle after address");
	b_latency_a: assert property (i_axi_awvalid && o_axi_awready &&
		i_axi_wvalid && o_axi_wready |=> !o_axi_bvalid ##1 o_axi_bvalid)
		else $error("write response not two cycles after transfer");
	b_release_a: assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
		else $error("write response held after bready");
	r_release_a: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid)
		else $error("read response held after rready");
	byte_data_a: assert property (o_axi_rvalid |->
		o_axi_rdata[31:8] == 24'h000000 && !o_axi_rresp[0])
		else $error("read data wider than a byte");
	ovh_inside_a: assert property (o_overhead |->
		o_integrate_even || o_integrate_odd)
		else $error("overhead tail outside integration");
endmodule

bind exposure_hdr_sequencer exposure_hdr_sequencer_chk exposure_hdr_sequencer_chk_i (
	.i_mclk, .i_rst_n, .i_axi_awvalid, .o_axi_awready, .i_axi_wvalid,
	.o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready, .i_axi_arvalid,
	.o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready,
	.o_integrate_even, .o_integrate_odd, .o_overhead
);

// ==== testbench/ctrl_model.sv ====
module ctrl_model (
	input  wire logic i_mclk,
	output logic      o_pin_a = 1'b0,
	output logic      o_pin_b = 1'b0,
	output logic      o_frame_req = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	task automatic frame_pulse;
		@(posedge i_mclk);
		o_frame_req <= 1'b1;
		repeat (4) @(posedge i_mclk);
		o_frame_req <= 1'b0;
	endtask

	// pin a always precedes frame request; gap of 1 is the shortest legal
	task automatic ext_exposure(input int gap, input bit dual);
		int k;
		@(posedge i_mclk);
		o_pin_a <= 1'b1;
		for (k = 1; k <= gap; k++) begin
			@(posedge i_mclk);
			if (dual && k == 1)
				o_pin_b <= 1'b1;
			if (k == gap)
				o_frame_req <= 1'b1;
		end
		repeat (4) @(posedge i_mclk);
		o_pin_a <= 1'b0;
		o_pin_b <= 1'b0;
		o_frame_req <= 1'b0;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
`include "exposure_hdr_sequencer_defines.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_mclk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [11:0] i_axi_awaddr = 12'h000;
	logic        i_axi_awvalid = 1'b0;
	logic [31:0] i_axi_wdata = 32'h00000000;
	logic        i_axi_wvalid = 1'b0;
	logic        i_axi_bready = 1'b0;
	logic [11:0] i_axi_araddr = 12'h000;
	logic        i_axi_arvalid = 1'b0;
	logic        i_axi_rready = 1'b0;
	logic [10:0] i_row_index = 11'h000;
	wire         o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
	wire  [1:0]  o_axi_bresp, o_axi_rresp;
	wire  [31:0] o_axi_rdata;
	wire         o_axi_rvalid, pin_a, pin_b, frame_req;
	wire         o_integrate_even, o_integrate_odd, o_overhead;
	wire         o_clip_enable, o_row_second_exposure;
	wire  [5:0]  o_clip_value;
	int          fails = 0;
	int          n_tests = 0;

	always #12.5 i_mclk = ~i_mclk;

	exposure_hdr_sequencer exposure_hdr_sequencer_i (
		.i_mclk, .i_rst_n, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready,
		.i_axi_wdata, .i_axi_wstrb(4'h1), .i_axi_wvalid, .o_axi_wready,
		.o_axi_bresp, .o_axi_bvalid, .i_axi_bready, .i_axi_araddr,
		.i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp,
		.o_axi_rvalid, .i_axi_rready, .i_exposure_start_pin_a(pin_a),
		.i_exposure_start_pin_b(pin_b), .i_frame_req(frame_req),
		.i_row_index, .o_integrate_even, .o_integrate_odd, .o_overhead,
		.o_clip_enable, .o_clip_value, .o_row_second_exposure);
	ctrl_model ctrl_model_i (.i_mclk, .o_pin_a(pin_a), .o_pin_b(pin_b),
		.o_frame_req(frame_req));

	task automatic test_done;
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic hang;
		fails++;
		test_done;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			fails++;
			$display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		output logic [1:0] r);
		int k;
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		k = 0;
		@(posedge i_mclk);
		i_axi_awaddr <= {2'b00, idx, 2'b00};
		i_axi_wdata <= {24'h000000, d};
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid <= 1'b1;
		i_axi_bready <= 1'b1;
		do begin
			if (k++ == 100)
				hang;
			@(posedge i_mclk);
			if (i_axi_awvalid && o_axi_awready === 1'b1) begin
				aw = 1;
				i_axi_awvalid <= 1'b0;
			end
			if (i_axi_wvalid && o_axi_wready === 1'b1) begin
				w = 1;
				i_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w));
		while (o_axi_bvalid !== 1'b1) begin
			if (k++ == 200)
				hang;
			@(posedge i_mclk);
		end
		r = o_axi_bresp;
		i_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		k = 0;
		@(posedge i_mclk);
		i_axi_araddr <= {2'b00, idx, 2'b00};
		i_axi_arvalid <= 1'b1;
		i_axi_rready <= 1'b1;
		do begin
			if (k++ == 100)
				hang;
			@(posedge i_mclk);
		end while (o_axi_arready !== 1'b1);
		i_axi_arvalid <= 1'b0;
		do begin
			if (k++ == 200)
				hang;
			@(posedge i_mclk);
		end while (o_axi_rvalid !== 1'b1);
		d = o_axi_rdata;
		r = o_axi_rresp;
		i_axi_rready <= 1'b0;
	endtask

	function automatic logic pick(input int s);
		case (s)
		0: return o_integrate_even;
		1: return o_integrate_odd;
		2: return o_overhead;
		3: return o_clip_enable && o_clip_value == 6'h05;
		default: return o_clip_enable && o_clip_value == 6'h0a;
		endcase
	endfunction

	// counts the cycles of the first high stretch of the chosen output
	task automatic measure(input int s, output int n);
		int k;
		n = 0;
		for (k = 0; pick(s) !== 1'b1; k++) begin
			if (k == 2000)
				hang;
			@(posedge i_mclk);
		end
		while (pick(s) === 1'b1 && n < 3000) begin
			@(posedge i_mclk);
			n++;
		end
	endtask

	// overhead 5 keeps runs short; lengths above one byte stay zero
	task automatic cfg(input logic [7:0] mode, input logic [7:0] l1,
		input logic [7:0] l2);
		logic [7:0] idx [8];
		logic [7:0] val [8];
		logic [1:0] r;
		idx = '{8'h49, 8'h2a, 8'h2b, 8'h2c, 8'h38, 8'h39, 8'h3a, 8'h29};
		val = '{8'h05, l1, 8'h00, 8'h00, l2, 8'h00, 8'h00, mode};
		foreach (idx[i])
			wr(idx[i], val[i], r);
	endtask

	function automatic int cycles(input int len);
		return (129 * (43 * 5 + 100 * len) + 99) / 100;
	endfunction

	task automatic t_defaults;
		logic [7:0]  idx [11];
		logic [7:0]  exp [11];
		logic [31:0] d;
		logic [1:0]  r;
		idx = '{8'h27, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h38, 8'h39, 8'h3a,
			8'h49, 8'h59, 8'h5a};
		exp = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h40, 8'h04, 8'h00,
			8'h0a, 8'h60, 8'h60};
		foreach (idx[i]) begin
			rd(idx[i], d, r);
			chk(d, {24'h000000, exp[i]});
			chk(r, `RESP_OKAY);
		end
	endtask

	task automatic t_map;
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h10, d, r);
		chk(r, `RESP_SLVERR);
		chk(d, 32'h00000000);
		wr(`IDX_STATUS, 8'h0f, r);
		chk(r, `RESP_SLVERR);
		wr(`IDX_CLIP_TWO, 8'h45, r);
		rd(`IDX_CLIP_TWO, d, r);
		chk(d, 32'h00000045);
	endtask

	// clip two (value 5 from t_map) until knee one remains, then clip three
	task automatic t_clip;
		int         a;
		int         b;
		int         n;
		logic [1:0] r;
		wr(`IDX_KNEE_ONE, 8'h02, r);
		wr(`IDX_SLOPE_COUNT, 8'h03, r);
		wr(`IDX_CLIP_THREE, 8'h4a, r);
		cfg(8'h00, 8'h04, 8'h01);
		fork
			ctrl_model_i.frame_pulse;
			measure(3, a);
			measure(4, b);
			measure(0, n);
		join
		chk_n(a, 129 * (4 - 2));
		chk_n(b, 129 * (2 - 1));
		chk_n(n, cycles(4));
		repeat (5) @(posedge i_mclk);
	endtask

	task automatic t_internal;
		int n;
		cfg(8'h00, 8'h01, 8'h01);
		fork
			ctrl_model_i.frame_pulse;
			measure(0, n);
		join
		chk_n(n, cycles(1));
		repeat (5) @(posedge i_mclk);
	endtask

	task automatic t_dual_int;
		int a;
		int b;
		cfg(8'h02, 8'h01, 8'h02);
		fork
			ctrl_model_i.frame_pulse;
			measure(0, a);
			measure(1, b);
		join
		chk_n(a, cycles(1));
		chk_n(b, cycles(2));
		repeat (5) @(posedge i_mclk);
	endtask

	task automatic t_external;
		int          n;
		logic [31:0] d;
		logic [1:0]  r;
		cfg(8'h01, 8'h01, 8'h01);
		fork
			ctrl_model_i.ext_exposure(1, 0);
			measure(2, n);
		join
		chk_n(n, (5547 * 5 + 99) / 100);
		rd(`IDX_MEASURED, d, r);
		chk(d, 32'h00000001);
		repeat (5) @(posedge i_mclk);
	endtask

	task automatic t_dual_ext;
		int a;
		int b;
		cfg(8'h03, 8'h01, 8'h01);
		fork
			ctrl_model_i.ext_exposure(3, 1);
			measure(0, a);
			measure(1, b);
		join
		chk_n(b > 0 && a > b, 1);
		chk_n(a - b, 1);
		chk_n(a > 5547 * 5 / 100, 1);
		repeat (5) @(posedge i_mclk);
	endtask

	task automatic t_rows;
		logic [1:0] r;
		for (int m = 0; m < 2; m++) begin
			wr(`IDX_SENSOR_COLOUR_TYPE, m[7:0], r);
			for (int w = 0; w < 4; w++) begin
				i_row_index <= w[10:0];
				repeat (2) @(posedge i_mclk);
				chk(o_row_second_exposure, m ? w[0] : w[1]);
			end
		end
	endtask

	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
		t_defaults;
		t_map;
		t_clip;
		t_internal;
		t_dual_int;
		t_external;
		t_dual_ext;
		t_rows;
		test_done;
	end
endmodule
